// ---- logic/ovw_fb_addr_gen.sv ----
module ovw_fb_addr_gen (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Frame control
  input  wire logic        frameStart,
  input  wire logic        fetchAck,
  // Buffer settings
  input  wire logic [31:0] bufStart,
  input  wire logic [23:0] bufEnd,
  input  wire logic [12:0] page_width_bytes,
  input  wire logic [12:0] lineOffset,
  // Fetch state
  output logic      [31:0] fetchAddr,
  output logic             bufDone
);

  typedef struct packed {
    logic [7:0]  bank;
    logic [23:0] runAddr;
    logic [12:0] lineBytes;
    logic        done;
  } ovw_gen_t;

  ovw_gen_t stReg;
  ovw_gen_t stNext;

  function automatic logic [23:0] addLow(input logic [23:0] a, input logic [23:0] b);
    addLow = a + b;
  endfunction

  always_comb begin
    logic [23:0] stepAddr;
    logic [12:0] nextBytes;
    stepAddr  = 24'h000000;
    nextBytes = 13'h0000;
    stNext    = stReg;
    if (frameStart) begin
      stNext.bank      = bufStart[31:ovw_pkg::BANK_LSB];
      stNext.runAddr   = bufStart[ovw_pkg::LOW_ADDR_W-1:0];
      stNext.lineBytes = 13'h0000;
      stNext.done      = bufStart[ovw_pkg::LOW_ADDR_W-1:0] >= bufEnd;
    end else if (fetchAck && !stReg.done) begin
      nextBytes = stReg.lineBytes + 13'(ovw_pkg::WORD_STEP);
      if (nextBytes >= page_width_bytes) begin
        // Line complete: skip the gap to the next line
        stepAddr         = addLow(addLow(stReg.runAddr, ovw_pkg::WORD_STEP),
                                  {11'h000, lineOffset});
        stNext.lineBytes = 13'h0000;
      end else begin
        stepAddr         = addLow(stReg.runAddr, ovw_pkg::WORD_STEP);
        stNext.lineBytes = nextBytes;
      end
      stNext.runAddr = stepAddr;
      stNext.done    = stepAddr >= bufEnd;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stReg <= '0;
    end else begin
      stReg <= stNext;
    end
  end

  assign fetchAddr = {stReg.bank, stReg.runAddr};
  assign bufDone   = stReg.done;

endmodule

// ---- logic/ovw_overlay_ctrl.sv ----
// Notes on behaviour
// - Per-pixel, select 0: alpha flag picks set, or key area when key control set.
// - Per-pixel, select 1: alpha from frame-buffer bits 27:24, 28 bpp only.
// - Window 1 control bit 0 switches window 1 on; 0 means off.
// - Each window's first position register holds left-top X[21:11], Y[10:0].
// - Each window's second position register holds right-bottom X[21:11], Y[10:0].
// - Window 1 alpha register holds six 4-bit values; bits 31:24 reserved.
// - Start register: top byte is bank A31:24, low 24 bits start A23:0.
// - End register holds A23:0 of buffer end, programmed by software.
// - Window 0 has two buffers with own start/end; window 1 has one.
// - Control bit 6 chooses per-plane (0) or per-pixel (1) blending.
// - Per-plane, select bit 1 applies set 0 (0) or set 1 (1).
// - Page width is visible line bytes; line offset is gap between lines.
//
// The strobed register port was left to the implementer.
module ovw_overlay_ctrl (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Register port
  input  wire logic [31:0] regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  // Screen scan and pixel from the display pipeline
  input  wire logic        frameStart,
  input  wire logic        pixValid,
  input  wire logic [10:0] scanX,
  input  wire logic [10:0] scanY,
  input  wire logic [31:0] pixData,
  input  wire logic        pixAlphaFlag,
  input  wire logic        pixKeyHit,
  input  wire logic        pix28Bpp,
  // Window visibility and window 1 alpha
  output logic             win0Visible,
  output logic             win1Visible,
  output logic      [3:0]  win1AlphaR,
  output logic      [3:0]  win1AlphaG,
  output logic      [3:0]  win1AlphaB,
  // Frame-buffer fetch
  output logic             fetchReq,
  output logic      [31:0] fetchAddr,
  input  wire logic        fetchAck
);

  typedef struct packed {
    logic        win0On;
    logic        win0BufSel;
    logic        win1On;
    logic        win1AlphaSel;
    logic        win1Blend;
    logic        key_area_alpha_control;
    logic [21:0] win0PosTl;
    logic [21:0] win0PosBr;
    logic [21:0] win1PosTl;
    logic [21:0] win1PosBr;
    logic [23:0] win1Alpha;
    logic [31:0] w0b0Start;
    logic [31:0] w0b1Start;
    logic [31:0] win1Start;
    logic [23:0] w0b0End;
    logic [23:0] w0b1End;
    logic [23:0] win1End;
    logic [25:0] win0Size;
    logic [25:0] win1Size;
    logic [31:0] rdData;
    logic        vis0;
    logic        vis1;
    logic [3:0]  alphaR;
    logic [3:0]  alphaG;
    logic [3:0]  alphaB;
    ovw_pkg::ovw_arb_t arb;
    logic [31:0] fAddr;
  } ovw_state_t;

  ovw_state_t stReg;
  ovw_state_t stNext;

  logic [31:0] gen0Addr;
  logic [31:0] gen1Addr;
  logic        gen0Done;
  logic        gen1Done;
  logic        ack0;
  logic        ack1;

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic inRect(input logic [10:0] x, input logic [10:0] y,
                                  input logic [21:0] tl, input logic [21:0] br);
    logic [10:0] lx;
    logic [10:0] ty;
    logic [10:0] rx;
    logic [10:0] by;
    lx = tl[ovw_pkg::POS_X_LSB +: ovw_pkg::COORD_W];
    ty = tl[ovw_pkg::POS_Y_LSB +: ovw_pkg::COORD_W];
    rx = br[ovw_pkg::POS_X_LSB +: ovw_pkg::COORD_W];
    by = br[ovw_pkg::POS_Y_LSB +: ovw_pkg::COORD_W];
    inRect = (x >= lx) && (x <= rx) && (y >= ty) && (y <= by);
  endfunction

  function automatic logic [3:0] alphaField(input logic [23:0] val, input int lsb);
    alphaField = val[lsb +: ovw_pkg::ALPHA_W];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Frame-buffer address generators

  assign ack0 = fetchAck && (stReg.arb == ovw_pkg::ARB_WIN0);
  assign ack1 = fetchAck && (stReg.arb == ovw_pkg::ARB_WIN1);

  ovw_fb_addr_gen u_gen0 (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .frameStart (frameStart),
    .fetchAck   (ack0),
    .bufStart   (stReg.win0BufSel ? stReg.w0b1Start : stReg.w0b0Start),
    .bufEnd     (stReg.win0BufSel ? stReg.w0b1End : stReg.w0b0End),
    .page_width_bytes  (stReg.win0Size[ovw_pkg::PAGE_W_LSB +: ovw_pkg::SIZE_FIELD_W]),
    .lineOffset (stReg.win0Size[ovw_pkg::LINE_OFF_LSB +: ovw_pkg::SIZE_FIELD_W]),
    .fetchAddr  (gen0Addr),
    .bufDone    (gen0Done)
  );

  ovw_fb_addr_gen u_gen1 (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .frameStart (frameStart),
    .fetchAck   (ack1),
    .bufStart   (stReg.win1Start),
    .bufEnd     (stReg.win1End),
    .page_width_bytes  (stReg.win1Size[ovw_pkg::PAGE_W_LSB +: ovw_pkg::SIZE_FIELD_W]),
    .lineOffset (stReg.win1Size[ovw_pkg::LINE_OFF_LSB +: ovw_pkg::SIZE_FIELD_W]),
    .fetchAddr  (gen1Addr),
    .bufDone    (gen1Done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic want0;
    logic want1;
    logic [3:0] pixA;
    want0  = 1'b0;
    want1  = 1'b0;
    pixA   = 4'h0;
    stNext = stReg;

    // Register writes
    if (regWr) begin
      unique case (regAddr)
        ovw_pkg::ADDR_WIN0_CTRL: begin
          stNext.win0On     = regWrData[ovw_pkg::CTRL_ON_BIT];
          stNext.win0BufSel = regWrData[ovw_pkg::CTRL_BUF_SEL];
        end
        ovw_pkg::ADDR_WIN1_CTRL: begin
          stNext.win1On       = regWrData[ovw_pkg::CTRL_ON_BIT];
          stNext.win1AlphaSel = regWrData[ovw_pkg::CTRL_ALPHA_SEL];
          stNext.win1Blend    = regWrData[ovw_pkg::CTRL_BLEND_BIT];
        end
        ovw_pkg::ADDR_WIN0_POS_TL: stNext.win0PosTl = regWrData[21:0];
        ovw_pkg::ADDR_WIN0_POS_BR: stNext.win0PosBr = regWrData[21:0];
        ovw_pkg::ADDR_WIN1_POS_TL: stNext.win1PosTl = regWrData[21:0];
        ovw_pkg::ADDR_WIN1_POS_BR: stNext.win1PosBr = regWrData[21:0];
        ovw_pkg::ADDR_WIN1_ALPHA:  stNext.win1Alpha = regWrData[23:0];
        ovw_pkg::ADDR_W0B0_START:  stNext.w0b0Start = regWrData;
        ovw_pkg::ADDR_W0B1_START:  stNext.w0b1Start = regWrData;
        ovw_pkg::ADDR_WIN1_START:  stNext.win1Start = regWrData;
        ovw_pkg::ADDR_W0B0_END:    stNext.w0b0End   = regWrData[23:0];
        ovw_pkg::ADDR_W0B1_END:    stNext.w0b1End   = regWrData[23:0];
        ovw_pkg::ADDR_WIN1_END:    stNext.win1End   = regWrData[23:0];
        ovw_pkg::ADDR_WIN0_SIZE:   stNext.win0Size  = regWrData[25:0];
        ovw_pkg::ADDR_WIN1_SIZE:   stNext.win1Size  = regWrData[25:0];
        ovw_pkg::ADDR_WIN1_KEY:    stNext.key_area_alpha_control  = regWrData[ovw_pkg::KEY_BLEND_BIT];
        default: begin
        end
      endcase
    end

    // Register reads, answered in the next cycle; unmapped reads zero
    stNext.rdData = 32'h00000000;
    if (regRd) begin
      unique case (regAddr)
        ovw_pkg::ADDR_WIN0_CTRL: begin
          stNext.rdData[ovw_pkg::CTRL_ON_BIT]  = stReg.win0On;
          stNext.rdData[ovw_pkg::CTRL_BUF_SEL] = stReg.win0BufSel;
        end
        ovw_pkg::ADDR_WIN1_CTRL: begin
          stNext.rdData[ovw_pkg::CTRL_ON_BIT]    = stReg.win1On;
          stNext.rdData[ovw_pkg::CTRL_ALPHA_SEL] = stReg.win1AlphaSel;
          stNext.rdData[ovw_pkg::CTRL_BLEND_BIT] = stReg.win1Blend;
        end
        ovw_pkg::ADDR_WIN0_POS_TL: stNext.rdData = {10'h000, stReg.win0PosTl};
        ovw_pkg::ADDR_WIN0_POS_BR: stNext.rdData = {10'h000, stReg.win0PosBr};
        ovw_pkg::ADDR_WIN1_POS_TL: stNext.rdData = {10'h000, stReg.win1PosTl};
        ovw_pkg::ADDR_WIN1_POS_BR: stNext.rdData = {10'h000, stReg.win1PosBr};
        ovw_pkg::ADDR_WIN1_ALPHA:  stNext.rdData = {8'h00, stReg.win1Alpha};
        ovw_pkg::ADDR_W0B0_START:  stNext.rdData = stReg.w0b0Start;
        ovw_pkg::ADDR_W0B1_START:  stNext.rdData = stReg.w0b1Start;
        ovw_pkg::ADDR_WIN1_START:  stNext.rdData = stReg.win1Start;
        ovw_pkg::ADDR_W0B0_END:    stNext.rdData = {8'h00, stReg.w0b0End};
        ovw_pkg::ADDR_W0B1_END:    stNext.rdData = {8'h00, stReg.w0b1End};
        ovw_pkg::ADDR_WIN1_END:    stNext.rdData = {8'h00, stReg.win1End};
        ovw_pkg::ADDR_WIN0_SIZE:   stNext.rdData = {6'h00, stReg.win0Size};
        ovw_pkg::ADDR_WIN1_SIZE:   stNext.rdData = {6'h00, stReg.win1Size};
        ovw_pkg::ADDR_WIN1_KEY:    stNext.rdData[ovw_pkg::KEY_BLEND_BIT] = stReg.key_area_alpha_control;
        default: begin
        end
      endcase
    end

    // Window hit test, one cycle after the pixel
    stNext.vis0 = pixValid && stReg.win0On
                  && inRect(scanX, scanY, stReg.win0PosTl, stReg.win0PosBr);
    stNext.vis1 = pixValid && stReg.win1On
                  && inRect(scanX, scanY, stReg.win1PosTl, stReg.win1PosBr);

    // Window 1 alpha choice
    if (pixValid) begin
      if (!stReg.win1Blend) begin
        if (stReg.win1AlphaSel) begin
          stNext.alphaR = alphaField(stReg.win1Alpha, ovw_pkg::ALPHA1_R_LSB);
          stNext.alphaG = alphaField(stReg.win1Alpha, ovw_pkg::ALPHA1_G_LSB);
          stNext.alphaB = alphaField(stReg.win1Alpha, ovw_pkg::ALPHA1_B_LSB);
        end else begin
          stNext.alphaR = alphaField(stReg.win1Alpha, ovw_pkg::ALPHA0_R_LSB);
          stNext.alphaG = alphaField(stReg.win1Alpha, ovw_pkg::ALPHA0_G_LSB);
          stNext.alphaB = alphaField(stReg.win1Alpha, ovw_pkg::ALPHA0_B_LSB);
        end
      end else if (stReg.win1AlphaSel) begin
        // Embedded alpha has meaning only in the 28 bpp layout
        pixA          = pix28Bpp ? pixData[ovw_pkg::PIX_ALPHA_LSB +: ovw_pkg::ALPHA_W]
                                 : 4'h0;
        stNext.alphaR = pixA;
        stNext.alphaG = pixA;
        stNext.alphaB = pixA;
      end else if (stReg.key_area_alpha_control ? pixKeyHit : pixAlphaFlag) begin
        stNext.alphaR = alphaField(stReg.win1Alpha, ovw_pkg::ALPHA1_R_LSB);
        stNext.alphaG = alphaField(stReg.win1Alpha, ovw_pkg::ALPHA1_G_LSB);
        stNext.alphaB = alphaField(stReg.win1Alpha, ovw_pkg::ALPHA1_B_LSB);
      end else begin
        stNext.alphaR = alphaField(stReg.win1Alpha, ovw_pkg::ALPHA0_R_LSB);
        stNext.alphaG = alphaField(stReg.win1Alpha, ovw_pkg::ALPHA0_G_LSB);
        stNext.alphaB = alphaField(stReg.win1Alpha, ovw_pkg::ALPHA0_B_LSB);
      end
    end

    // Fetch arbitration: one outstanding request, window 0 first whenever both windows want
    want0 = stReg.win0On && !gen0Done;
    want1 = stReg.win1On && !gen1Done;
    if (frameStart) begin
      stNext.arb = ovw_pkg::ARB_IDLE;
    end else begin
      unique case (stReg.arb)
        ovw_pkg::ARB_IDLE: begin
          if (want0) begin
            stNext.arb = ovw_pkg::ARB_WIN0;
          end else if (want1) begin
            stNext.arb = ovw_pkg::ARB_WIN1;
          end
        end
        ovw_pkg::ARB_WIN0: begin
          if (fetchAck) begin
            stNext.arb = ovw_pkg::ARB_IDLE;
          end
        end
        ovw_pkg::ARB_WIN1: begin
          if (fetchAck) begin
            stNext.arb = ovw_pkg::ARB_IDLE;
          end
        end
        default: stNext.arb = ovw_pkg::ARB_IDLE;
      endcase
    end
    stNext.fAddr = (stNext.arb == ovw_pkg::ARB_WIN1) ? gen1Addr : gen0Addr;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stReg     <= '0;
      stReg.arb <= ovw_pkg::ARB_IDLE;
    end else begin
      stReg <= stNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign regRdData   = stReg.rdData;
  assign win0Visible = stReg.vis0;
  assign win1Visible = stReg.vis1;
  assign win1AlphaR  = stReg.alphaR;
  assign win1AlphaG  = stReg.alphaG;
  assign win1AlphaB  = stReg.alphaB;
  assign fetchReq    = stReg.arb[0];
  assign fetchAddr   = stReg.fAddr;

endmodule

// ---- logic/ovw_pkg.sv ----
package ovw_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_WIN0_CTRL   = 32'h4C800010;
  localparam logic [31:0] ADDR_WIN1_CTRL   = 32'h4C800014;
  localparam logic [31:0] ADDR_WIN0_POS_TL = 32'h4C800028;
  localparam logic [31:0] ADDR_WIN0_POS_BR = 32'h4C80002C;
  localparam logic [31:0] ADDR_WIN1_POS_TL = 32'h4C800034;
  localparam logic [31:0] ADDR_WIN1_POS_BR = 32'h4C800038;
  localparam logic [31:0] ADDR_WIN1_ALPHA  = 32'h4C80003C;
  localparam logic [31:0] ADDR_W0B0_START  = 32'h4C800064;
  localparam logic [31:0] ADDR_W0B1_START  = 32'h4C800068;
  localparam logic [31:0] ADDR_WIN1_START  = 32'h4C80006C;
  localparam logic [31:0] ADDR_W0B0_END    = 32'h4C80007C;
  localparam logic [31:0] ADDR_W0B1_END    = 32'h4C800080;
  localparam logic [31:0] ADDR_WIN1_END    = 32'h4C800084;
  localparam logic [31:0] ADDR_WIN0_SIZE   = 32'h4C8000A0;
  localparam logic [31:0] ADDR_WIN1_SIZE   = 32'h4C8000A4;
  localparam logic [31:0] ADDR_WIN1_KEY    = 32'h4C8000B0;

  // Control register fields
  localparam int CTRL_ON_BIT      = 0;
  localparam int CTRL_ALPHA_SEL   = 1;
  localparam int CTRL_BUF_SEL     = 1;
  localparam int CTRL_BLEND_BIT   = 6;
  localparam int KEY_BLEND_BIT    = 26;

  // Position fields
  localparam int POS_X_LSB        = 11;
  localparam int POS_Y_LSB        = 0;
  localparam int COORD_W          = 11;

  // Alpha fields
  localparam int ALPHA0_R_LSB     = 20;
  localparam int ALPHA0_G_LSB     = 16;
  localparam int ALPHA0_B_LSB     = 12;
  localparam int ALPHA1_R_LSB     = 8;
  localparam int ALPHA1_G_LSB     = 4;
  localparam int ALPHA1_B_LSB     = 0;
  localparam int ALPHA_W          = 4;
  localparam int PIX_ALPHA_LSB    = 24;

  // Frame-buffer address fields
  localparam int BANK_LSB         = 24;
  localparam int LOW_ADDR_W       = 24;
  localparam int PAGE_W_LSB       = 0;
  localparam int LINE_OFF_LSB     = 13;
  localparam int SIZE_FIELD_W     = 13;
  localparam logic [23:0] WORD_STEP = 24'h000004;

  // Reset values
  localparam logic [31:0] REG_RESET = 32'h00000000;

  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_WIN0 = 2'b01,
    ARB_WIN1 = 2'b11
  } ovw_arb_t;

endpackage

// ---- sim/ovw_overlay_ctrl_assertions.sv ----
module ovw_overlay_ctrl_assertions (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // Register port
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData,
  // Pixel path
  input wire logic        frameStart,
  input wire logic        pixValid,
  input wire logic [10:0] scanX,
  input wire logic [10:0] scanY,
  input wire logic [31:0] pixData,
  input wire logic        pixAlphaFlag,
  input wire logic        pixKeyHit,
  input wire logic        pix28Bpp,
  input wire logic        win0Visible,
  input wire logic        win1Visible,
  input wire logic [3:0]  win1AlphaR,
  input wire logic [3:0]  win1AlphaG,
  input wire logic [3:0]  win1AlphaB,
  // Fetch
  input wire logic        fetchReq,
  input wire logic [31:0] fetchAddr,
  input wire logic        fetchAck
);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow copies of the window 1 settings
  logic [31:0] c1Reg;
  logic [21:0] tlReg, brReg;
  logic [23:0] alReg;
  logic        keyReg, vis1, pick1;
  logic [11:0] emb, plane, pixA, outA;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      c1Reg <= 32'h00000000;
      tlReg <= 22'h000000;
      brReg <= 22'h000000;
      alReg <= 24'h000000;
      keyReg <= 1'b0;
    end else if (regWr) begin
      case (regAddr)
        ovw_pkg::ADDR_WIN1_CTRL: c1Reg <= regWrData;
        ovw_pkg::ADDR_WIN1_POS_TL: tlReg <= regWrData[21:0];
        ovw_pkg::ADDR_WIN1_POS_BR: brReg <= regWrData[21:0];
        ovw_pkg::ADDR_WIN1_ALPHA: alReg <= regWrData[23:0];
        ovw_pkg::ADDR_WIN1_KEY: keyReg <= regWrData[26];
        default: ;
      endcase
    end
  end
  assign vis1 = c1Reg[0] && scanX >= tlReg[21:11] && scanX <= brReg[21:11]
                && scanY >= tlReg[10:0] && scanY <= brReg[10:0];
  assign emb = pix28Bpp ? {3{pixData[27:24]}} : 12'h000;
  assign pick1 = keyReg ? pixKeyHit : pixAlphaFlag;
  assign plane = c1Reg[1] ? alReg[11:0] : alReg[23:12];
  assign pixA = pick1 ? alReg[11:0] : alReg[23:12];
  assign outA = {win1AlphaR, win1AlphaG, win1AlphaB};
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_rd_idle; !$past(regRd) |-> regRdData == 32'h00000000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_alpha_rd;
    $past(regRd) && $past(regAddr) == ovw_pkg::ADDR_WIN1_ALPHA |-> regRdData == {8'h00, alReg};
  endproperty
  a_alpha_rd: assert property (p_alpha_rd) else $error("alpha readback wrong");
  property p_tl_rd;
    $past(regRd) && $past(regAddr) == ovw_pkg::ADDR_WIN1_POS_TL |-> regRdData == {10'h000, tlReg};
  endproperty
  a_tl_rd: assert property (p_tl_rd) else $error("top-left readback wrong");
  property p_br_rd;
    $past(regRd) && $past(regAddr) == ovw_pkg::ADDR_WIN1_POS_BR |-> regRdData == {10'h000, brReg};
  endproperty
  a_br_rd: assert property (p_br_rd) else $error("bottom-right readback wrong");
  property p_win1_vis; pixValid |=> win1Visible == $past(vis1); endproperty
  a_win1_vis: assert property (p_win1_vis) else $error("window 1 visibility wrong");
  property p_win0_vis; win0Visible |-> $past(pixValid); endproperty
  a_win0_vis: assert property (p_win0_vis) else $error("window 0 visible without pixel");
  property p_alpha_plane; pixValid && !c1Reg[6] |=> outA == $past(plane); endproperty
  a_alpha_plane: assert property (p_alpha_plane) else $error("plane alpha wrong");
  property p_alpha_emb; pixValid && c1Reg[6] && c1Reg[1] |=> outA == $past(emb); endproperty
  a_alpha_emb: assert property (p_alpha_emb) else $error("embedded alpha wrong");
  property p_alpha_pix; pixValid && c1Reg[6] && !c1Reg[1] |=> outA == $past(pixA); endproperty
  a_alpha_pix: assert property (p_alpha_pix) else $error("pixel alpha set wrong");
  property p_fetch_hold;
    fetchReq && !fetchAck && !frameStart |=> fetchReq && $stable(fetchAddr);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch dropped early");
  property p_fetch_ack; fetchReq && fetchAck |=> !fetchReq; endproperty
  a_fetch_ack: assert property (p_fetch_ack) else $error("fetch not ended by ack");
  property p_frame_abort; frameStart |=> !fetchReq; endproperty
  a_frame_abort: assert property (p_frame_abort) else $error("fetch survives frame start");
endmodule

bind ovw_overlay_ctrl ovw_overlay_ctrl_assertions ovw_overlay_ctrl_assertions_inst (
  .sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .frameStart(frameStart), .pixValid(pixValid),
  .scanX(scanX), .scanY(scanY), .pixData(pixData), .pixAlphaFlag(pixAlphaFlag),
  .pixKeyHit(pixKeyHit), .pix28Bpp(pix28Bpp), .win0Visible(win0Visible),
  .win1Visible(win1Visible), .win1AlphaR(win1AlphaR), .win1AlphaG(win1AlphaG),
  .win1AlphaB(win1AlphaB), .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchAck(fetchAck)
);

// ---- sim/ovw_overlay_ctrl_test.sv ----
module ovw_overlay_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, frameStart = 1'b0;
  logic        pixValid = 1'b0, pixAlphaFlag = 1'b0, pixKeyHit = 1'b0, pix28Bpp = 1'b0;
  logic        fetchAck = 1'b0, win0Visible, win1Visible, fetchReq;
  logic [10:0] scanX = 11'h000, scanY = 11'h000;
  logic [31:0] regAddr = 32'h00000000, regWrData = 32'h00000000, pixData = 32'h00000000;
  logic [31:0] regRdData, fetchAddr, seed = 32'h00002630;
  logic [3:0]  win1AlphaR, win1AlphaG, win1AlphaB;
  logic [31:0] m [logic [31:0]];
  int          miscompares = 0, totalChecks = 0;
  logic [31:0] addrs [16] = '{ovw_pkg::ADDR_WIN0_CTRL, ovw_pkg::ADDR_WIN1_CTRL,
    ovw_pkg::ADDR_WIN0_POS_TL, ovw_pkg::ADDR_WIN0_POS_BR, ovw_pkg::ADDR_WIN1_POS_TL,
    ovw_pkg::ADDR_WIN1_POS_BR, ovw_pkg::ADDR_WIN1_ALPHA, ovw_pkg::ADDR_W0B0_START,
    ovw_pkg::ADDR_W0B1_START, ovw_pkg::ADDR_WIN1_START, ovw_pkg::ADDR_W0B0_END,
    ovw_pkg::ADDR_W0B1_END, ovw_pkg::ADDR_WIN1_END, ovw_pkg::ADDR_WIN0_SIZE,
    ovw_pkg::ADDR_WIN1_SIZE, ovw_pkg::ADDR_WIN1_KEY};

  ovw_overlay_ctrl ovw_overlay_ctrl_inst (
    .sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .frameStart(frameStart), .pixValid(pixValid),
    .scanX(scanX), .scanY(scanY), .pixData(pixData), .pixAlphaFlag(pixAlphaFlag),
    .pixKeyHit(pixKeyHit), .pix28Bpp(pix28Bpp), .win0Visible(win0Visible),
    .win1Visible(win1Visible), .win1AlphaR(win1AlphaR), .win1AlphaG(win1AlphaG),
    .win1AlphaB(win1AlphaB), .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchAck(fetchAck)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Bits that each register keeps; zero for unmapped places
  function automatic logic [31:0] msk(input logic [31:0] a);
    case (a)
      ovw_pkg::ADDR_WIN0_CTRL: return 32'h00000003;
      ovw_pkg::ADDR_WIN1_CTRL: return 32'h00000043;
      ovw_pkg::ADDR_WIN0_POS_TL, ovw_pkg::ADDR_WIN0_POS_BR, ovw_pkg::ADDR_WIN1_POS_TL,
      ovw_pkg::ADDR_WIN1_POS_BR: return 32'h003FFFFF;
      ovw_pkg::ADDR_W0B0_START, ovw_pkg::ADDR_W0B1_START,
      ovw_pkg::ADDR_WIN1_START: return 32'hFFFFFFFF;
      ovw_pkg::ADDR_WIN0_SIZE, ovw_pkg::ADDR_WIN1_SIZE: return 32'h03FFFFFF;
      ovw_pkg::ADDR_WIN1_KEY: return 32'h04000000;
      ovw_pkg::ADDR_WIN1_ALPHA, ovw_pkg::ADDR_W0B0_END, ovw_pkg::ADDR_W0B1_END,
      ovw_pkg::ADDR_WIN1_END: return 32'h00FFFFFF;
      default: return 32'h00000000;
    endcase
  endfunction
  function automatic logic [31:0] get(input logic [31:0] a);
    return m.exists(a) ? m[a] : 32'h00000000;
  endfunction
  function automatic logic vis(input logic [31:0] c, t, b, input int x, y);
    return c[0] && x >= t[21:11] && x <= b[21:11] && y >= t[10:0] && y <= b[10:0];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    if (msk(a) != 32'h00000000) m[a] = d & msk(a);
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, get(a));
  endtask
  task automatic pix();
    logic [31:0] r, d, c, al;
    logic [11:0] ea;
    r = rnd();
    d = rnd();
    c = get(ovw_pkg::ADDR_WIN1_CTRL);
    al = get(ovw_pkg::ADDR_WIN1_ALPHA);
    if (!c[6]) ea = c[1] ? al[11:0] : al[23:12];
    else if (c[1]) ea = r[14] ? {3{d[27:24]}} : 12'h000;
    else if (get(ovw_pkg::ADDR_WIN1_KEY) != 0) ea = r[13] ? al[11:0] : al[23:12];
    else ea = r[12] ? al[11:0] : al[23:12];
    @(posedge sys_clk);
    pixValid <= 1'b1;
    scanX <= {5'h00, r[5:0]};
    scanY <= {5'h00, r[11:6]};
    pixAlphaFlag <= r[12];
    pixKeyHit <= r[13];
    pix28Bpp <= r[14];
    pixData <= d;
    @(posedge sys_clk);
    pixValid <= 1'b0;
    #1 chk(win0Visible, vis(get(ovw_pkg::ADDR_WIN0_CTRL), get(ovw_pkg::ADDR_WIN0_POS_TL),
        get(ovw_pkg::ADDR_WIN0_POS_BR), r[5:0], r[11:6]));
    chk(win1Visible, vis(c, get(ovw_pkg::ADDR_WIN1_POS_TL), get(ovw_pkg::ADDR_WIN1_POS_BR),
        r[5:0], r[11:6]));
    chk({win1AlphaR, win1AlphaG, win1AlphaB}, ea);
  endtask
  // One frame: two lines of 16 visible bytes, then an 8-byte gap
  task automatic frame(input logic [31:0] sa, ea, za, ctl0, ctl1);
    logic [31:0] s;
    logic [23:0] lo;
    int          bytes, n;
    s = rnd() & 32'hFF0FFFF0;
    lo = s[23:0];
    bytes = 0;
    wr(sa, s);
    wr(ea, {8'h00, lo + 24'd48});
    wr(za, 32'h00010010);
    wr(ovw_pkg::ADDR_WIN0_CTRL, ctl0);
    wr(ovw_pkg::ADDR_WIN1_CTRL, ctl1);
    @(posedge sys_clk);
    frameStart <= 1'b1;
    @(posedge sys_clk);
    frameStart <= 1'b0;
    while (lo < s[23:0] + 24'd48) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        #1 n++;
      end while (!fetchReq && n < 40);
      chk(fetchReq, 1);
      chk(fetchAddr, {s[31:24], lo});
      repeat (rnd() % 3) @(posedge sys_clk);
      @(posedge sys_clk);
      fetchAck <= 1'b1;
      @(posedge sys_clk);
      fetchAck <= 1'b0;
      lo += 24'd4;
      bytes += 4;
      if (bytes == 16) begin
        lo += 24'd8;
        bytes = 0;
      end
    end
    repeat (30) @(posedge sys_clk);
    #1 chk(fetchReq, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    foreach (addrs[i]) rd(addrs[i]);
    rd(32'h4C800000);
    wr(32'h4C800000, rnd());
    rd(32'h4C800000);
    foreach (addrs[i]) begin
      wr(addrs[i], rnd());
      rd(addrs[i]);
    end
    wr(ovw_pkg::ADDR_WIN0_POS_TL, 32'h00004004);
    wr(ovw_pkg::ADDR_WIN0_POS_BR, 32'h0000A00A);
    wr(ovw_pkg::ADDR_WIN1_POS_TL, 32'h00008008);
    wr(ovw_pkg::ADDR_WIN1_POS_BR, 32'h0001401E);
    for (int k = 0; k < 8; k++) begin
      wr(ovw_pkg::ADDR_WIN1_CTRL, (k[2] << 6) | (k[1] << 1) | (rnd() & 1));
      wr(ovw_pkg::ADDR_WIN0_CTRL, rnd() & 1);
      wr(ovw_pkg::ADDR_WIN1_KEY, k[0] << 26);
      wr(ovw_pkg::ADDR_WIN1_ALPHA, rnd());
      repeat (16) pix();
    end
    frame(ovw_pkg::ADDR_W0B0_START, ovw_pkg::ADDR_W0B0_END, ovw_pkg::ADDR_WIN0_SIZE, 1, 0);
    frame(ovw_pkg::ADDR_W0B1_START, ovw_pkg::ADDR_W0B1_END, ovw_pkg::ADDR_WIN0_SIZE, 3, 0);
    frame(ovw_pkg::ADDR_WIN1_START, ovw_pkg::ADDR_WIN1_END, ovw_pkg::ADDR_WIN1_SIZE, 0, 1);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    m.delete();
    rd(ovw_pkg::ADDR_WIN1_ALPHA);
    conclude();
  end
endmodule
